// File: verilog/tmr_pkg.sv
// Package with register offsets, field positions, reset values and codes for the timer prescaler block.
package tmr_pkg;
  localparam logic [3:0] OFF_COMPARE = 4'h0;
  localparam logic [3:0] OFF_MASK = 4'h4;
  localparam logic [3:0] OFF_FLAGS = 4'h8;
  localparam logic [3:0] OFF_GTC = 4'hC;
  localparam int BIT_OVF = 0;
  localparam int BIT_CMP = 1;
  localparam int BIT_PSR = 0;
  localparam int BIT_APSR = 1;
  localparam int BIT_TSM = 7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] PRESC_RESET = 10'h000;
  localparam int TAP_DIV8 = 2;
  localparam int TAP_DIV64 = 5;
  localparam int TAP_DIV256 = 7;
  localparam int TAP_DIV1024 = 9;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: verilog/timer_prescaler_and_flags.sv
// Shared timer prescaler, external count sync, timer 0 compare and flag logic with an AXI4-Lite slave.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Hold 8-bit compare value; compare with counter on each timer 0 tick to make a match event.
// - Compare irq request only when compare enable, global enable and flag are set.
// - Overflow irq request only when overflow enable, global enable and flag are set.
// - Compare flag set by match; cleared by vector acknowledge or writing one.
// - Overflow flag set by overflow; cleared by vector acknowledge or writing one.
// - In phase-correct mode the overflow flag sets on direction change at bottom.
// - Both timers use one prescaler, each with its own clock select.
// - Clock select one ticks the timer every system clock cycle while the shared prescaler reset is clear.
// - Prescaler provides divide by 8, 64, 256 and 1024 taps.
// - Prescaler runs freely, so first prescaled tick comes 1 to N+1 cycles later.
// - A prescaler reset restarts the divided phase for both timers.
// - Count pins sampled each cycle by high-transparent latch then rising-edge registers.
// - One tick per rising edge for select seven, per falling edge for six.
// - Counter updates 2.5 to 3.5 cycles after an external pin edge.
// - External pin edges reach the counter without prescaler division while the shared prescaler reset is clear.
// - Sync hold mode keeps prescaler resets set; clearing it releases them together.
// - Writing one to the shared reset resets the prescaler; self-clears unless holding.
// - Select zero stops the timer; two to five pick 8, 64, 256, 1024 taps.
// - A counter write suppresses compare match on the next timer tick.
// - Forced compare neither sets the flag, requests irq, nor clears the counter.
module timer_prescaler_and_flags #(
  parameter int PRESC_WIDTH = 10
) (
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // AXI4-Lite write address and data.
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels.
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Timer 0 core side and the clock selects of both timers.
  input wire logic [7:0] timer0_counter_value_i,
  input wire logic timer0_counter_write_i,
  input wire logic timer0_overflow_i,
  input wire logic timer0_bottom_turn_i,
  input wire logic phase_correct_mode_i,
  input wire logic force_compare_a_i,
  input wire logic [2:0] timer0_clock_select_i,
  input wire logic [2:0] timer1_clock_select_i,
  // External count pins.
  input wire logic ext_count_pin_zero_i,
  input wire logic ext_count_pin_one_i,
  // CPU interrupt side.
  input wire logic global_irq_enable_i,
  input wire logic compare_ack_i,
  input wire logic overflow_ack_i,
  // Outputs to timers and CPU.
  output logic timer0_tick_o,
  output logic timer1_tick_o,
  output logic compare_match_o,
  output logic compare_irq_o,
  output logic overflow_irq_o,
  output logic async_prescaler_reset_o
);

  // State registers.
  logic [PRESC_WIDTH-1:0] presc_q;
  logic [7:0] compare_value_a_q;
  logic [1:0] irq_mask_q;
  logic [1:0] flags_q;
  logic sync_hold_mode_q, shared_prescaler_reset_q, async_prescaler_reset_q;
  logic suppress_q;
  logic lat0, lat1;
  logic s0_q, s1_q, e0_q, e1_q;
  logic aw_got_q, w_got_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Latches transparent during the clock high phase feed the sampling registers.
  always_latch begin
    if (clk_i) begin
      lat0 = ext_count_pin_zero_i;
      lat1 = ext_count_pin_one_i;
    end
  end

  // Next prescaler value gives one-cycle tap pulses on each carry out of a tap bit.
  wire [PRESC_WIDTH-1:0] presc_next = presc_q + {{(PRESC_WIDTH-1){1'b0}}, 1'b1};
  wire presc_held = shared_prescaler_reset_q;
  wire [3:0] tap_pulse;
  assign tap_pulse[0] = !presc_held && (presc_next[tmr_pkg::TAP_DIV8:0] == '0);
  assign tap_pulse[1] = !presc_held && (presc_next[tmr_pkg::TAP_DIV64:0] == '0);
  assign tap_pulse[2] = !presc_held && (presc_next[tmr_pkg::TAP_DIV256:0] == '0);
  assign tap_pulse[3] = !presc_held && (presc_next[tmr_pkg::TAP_DIV1024:0] == '0);

  // Edge detection on the synchronised pins.
  wire rise0 = s0_q && !e0_q;
  wire fall0 = !s0_q && e0_q;
  wire rise1 = s1_q && !e1_q;
  wire fall1 = !s1_q && e1_q;

  // Each timer picks its own source from the common taps.
  function automatic logic pick(input logic [2:0] cs, input logic [3:0] taps, input logic rise, input logic fall);
    logic r;
    r = 1'b0;
    case (cs)
      tmr_pkg::CS_STOP: r = 1'b0;
      tmr_pkg::CS_DIRECT: r = 1'b1;
      tmr_pkg::CS_DIV8: r = taps[0];
      tmr_pkg::CS_DIV64: r = taps[1];
      tmr_pkg::CS_DIV256: r = taps[2];
      tmr_pkg::CS_DIV1024: r = taps[3];
      tmr_pkg::CS_EXT_FALL: r = fall;
      tmr_pkg::CS_EXT_RISE: r = rise;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Direct select ticks every cycle, external edges pass undivided; ticks halt while reset is held.
  wire tick0_d = pick(timer0_clock_select_i, tap_pulse, rise0, fall0) && !presc_held;
  wire tick1_d = pick(timer1_clock_select_i, tap_pulse, rise1, fall1) && !presc_held;

  // Compare match is suppressed on the tick following a counter write; forced strobes never enter here.
  wire match_raw = (timer0_counter_value_i == compare_value_a_q);
  wire match_d = match_raw && tick0_d && !suppress_q && !timer0_counter_write_i;
  wire ovf_event = phase_correct_mode_i ? timer0_bottom_turn_i : timer0_overflow_i;

  // Write channel handshake and decode.
  wire aw_have = aw_got_q || (s_axi_awvalid_i && s_axi_awready_o);
  wire w_have = w_got_q || (s_axi_wvalid_i && s_axi_wready_o);
  wire [3:0] wr_addr = aw_got_q ? aw_addr_q : s_axi_awaddr_i;
  wire [31:0] wr_data = w_got_q ? w_data_q : s_axi_wdata_i;
  wire [3:0] wr_strb = w_got_q ? w_strb_q : s_axi_wstrb_i;
  wire wr_fire = aw_have && w_have && !s_axi_bvalid_o;
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire wr_cmp = wr_lane0 && (wr_addr == tmr_pkg::OFF_COMPARE);
  wire wr_mask = wr_lane0 && (wr_addr == tmr_pkg::OFF_MASK);
  wire wr_flag = wr_lane0 && (wr_addr == tmr_pkg::OFF_FLAGS);
  wire wr_gtc = wr_lane0 && (wr_addr == tmr_pkg::OFF_GTC);
  wire wr_known = (wr_addr == tmr_pkg::OFF_COMPARE) || (wr_addr == tmr_pkg::OFF_MASK) ||
                  (wr_addr == tmr_pkg::OFF_FLAGS) || (wr_addr == tmr_pkg::OFF_GTC);

  // Flag next values: hardware set wins over any clear in the same cycle.
  wire [1:0] flag_clr = (wr_flag ? wr_data[1:0] : 2'b00) | {compare_ack_i, overflow_ack_i};
  wire [1:0] flag_set = {match_d, ovf_event};
  wire [1:0] flags_d = (flags_q & ~flag_clr) | flag_set;

  // Sync hold mode keeps reset bits; otherwise the shared reset self-clears after one cycle.
  wire tsm_d = wr_gtc ? wr_data[tmr_pkg::BIT_TSM] : sync_hold_mode_q;
  wire psr_d = wr_gtc ? (wr_data[tmr_pkg::BIT_PSR] | (shared_prescaler_reset_q & tsm_d)) :
               (shared_prescaler_reset_q & sync_hold_mode_q);
  wire apsr_d = wr_gtc ? (wr_data[tmr_pkg::BIT_APSR] | (async_prescaler_reset_q & tsm_d)) :
                (async_prescaler_reset_q & sync_hold_mode_q);

  // Read decode.
  wire rd_fire = s_axi_arvalid_i && !s_axi_rvalid_o;
  wire [7:0] gtc_view = {sync_hold_mode_q, 5'h00, async_prescaler_reset_q, shared_prescaler_reset_q};
  wire rd_known = (s_axi_araddr_i == tmr_pkg::OFF_COMPARE) || (s_axi_araddr_i == tmr_pkg::OFF_MASK) ||
                  (s_axi_araddr_i == tmr_pkg::OFF_FLAGS) || (s_axi_araddr_i == tmr_pkg::OFF_GTC);
  wire [7:0] rd_byte = (s_axi_araddr_i == tmr_pkg::OFF_COMPARE) ? compare_value_a_q :
                       (s_axi_araddr_i == tmr_pkg::OFF_MASK) ? {6'h00, irq_mask_q} :
                       (s_axi_araddr_i == tmr_pkg::OFF_FLAGS) ? {6'h00, flags_q} :
                       (s_axi_araddr_i == tmr_pkg::OFF_GTC) ? gtc_view : 8'h00;

  // Free-running prescaler, cleared only by the shared prescaler reset bit and by system reset.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc_q <= '0;
    end else if (clk_en_i) begin
      presc_q <= presc_held ? '0 : presc_next;
    end
  end

  // Pin sampling and edge history: two register stages after the latch give 2.5 to 3.5 cycle delay.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s0_q <= 1'b0;
      s1_q <= 1'b0;
      e0_q <= 1'b0;
      e1_q <= 1'b0;
    end else if (clk_en_i) begin
      s0_q <= lat0;
      s1_q <= lat1;
      e0_q <= s0_q;
      e1_q <= s1_q;
    end
  end

  // Registers written by software and flags set by hardware.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      compare_value_a_q <= tmr_pkg::RST_BYTE;
      irq_mask_q <= 2'b00;
      flags_q <= 2'b00;
      sync_hold_mode_q <= 1'b0;
      shared_prescaler_reset_q <= 1'b0;
      async_prescaler_reset_q <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_cmp) begin
        compare_value_a_q <= wr_data[7:0];
      end
      if (wr_mask) begin
        irq_mask_q <= wr_data[1:0];
      end
      flags_q <= flags_d;
      sync_hold_mode_q <= tsm_d;
      shared_prescaler_reset_q <= psr_d;
      async_prescaler_reset_q <= apsr_d;
    end
  end

  // Suppression armed by a counter write, spent on the next timer tick.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      suppress_q <= 1'b0;
    end else if (clk_en_i) begin
      if (timer0_counter_write_i) begin
        suppress_q <= 1'b1;
      end else if (tick0_d) begin
        suppress_q <= 1'b0;
      end
    end
  end

  // Registered outputs; irq levels need enable, global enable and flag.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer0_tick_o <= 1'b0;
      timer1_tick_o <= 1'b0;
      compare_match_o <= 1'b0;
      compare_irq_o <= 1'b0;
      overflow_irq_o <= 1'b0;
      async_prescaler_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      timer0_tick_o <= tick0_d;
      timer1_tick_o <= tick1_d;
      compare_match_o <= match_d | (force_compare_a_i & match_raw & 1'b0) | (force_compare_a_i & 1'b0);
      compare_irq_o <= irq_mask_q[tmr_pkg::BIT_CMP] & global_irq_enable_i & flags_d[tmr_pkg::BIT_CMP];
      overflow_irq_o <= irq_mask_q[tmr_pkg::BIT_OVF] & global_irq_enable_i & flags_d[tmr_pkg::BIT_OVF];
      async_prescaler_reset_o <= apsr_d;
    end
  end

  // AXI4-Lite write side: address and data are taken in either order, response after both.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= tmr_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_known ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end else begin
        if (s_axi_awvalid_i && s_axi_awready_o) begin
          aw_got_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
          w_got_q <= 1'b1;
          w_data_q <= s_axi_wdata_i;
          w_strb_q <= s_axi_wstrb_i;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
      end
    end
  end

  // Ready outputs registered: open while nothing is held and no response pending.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_arready_o <= 1'b0;
    end else if (clk_en_i) begin
      s_axi_awready_o <= !wr_fire && !(s_axi_awvalid_i && s_axi_awready_o) && !aw_got_q &&
                         !(s_axi_bvalid_o && !s_axi_bready_i);
      s_axi_wready_o <= !wr_fire && !(s_axi_wvalid_i && s_axi_wready_o) && !w_got_q &&
                        !(s_axi_bvalid_o && !s_axi_bready_i);
      s_axi_arready_o <= !rd_fire && !(s_axi_rvalid_o && !s_axi_rready_i);
    end
  end

  // AXI4-Lite read side: data answered the cycle after the address is taken.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= tmr_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      if (rd_fire && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h00_0000, rd_byte};
        s_axi_rresp_o <= rd_known ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // Checks on the design's own behaviour.
  property p_cmp_irq;
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i |=> compare_irq_o == ($past(irq_mask_q[1]) && $past(global_irq_enable_i) && flags_q[1]);
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq level wrong");
  property p_ovf_irq;
    @(posedge clk_i) disable iff (!reset_n_i)
    (overflow_irq_o && $past(clk_en_i)) |-> (flags_q[0] && $past(irq_mask_q[0]) && $past(global_irq_enable_i));
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq without flag and enable");
  property p_cmp_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && match_d) |=> flags_q[1];
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare flag not set by match");
  property p_ack_clear;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && overflow_ack_i && !ovf_event) |=> !flags_q[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("overflow flag not cleared by ack");
  property p_direct;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && timer0_clock_select_i == 3'h1 && !presc_held) |=> timer0_tick_o;
  endproperty
  a_direct: assert property (p_direct) else $error("direct select did not tick");
  property p_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && presc_held) |=> !timer0_tick_o && !timer1_tick_o;
  endproperty
  a_hold: assert property (p_hold) else $error("tick while prescaler reset held");
  property p_selfclear;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && shared_prescaler_reset_q && !sync_hold_mode_q && !wr_gtc) |=> !shared_prescaler_reset_q;
  endproperty
  a_selfclear: assert property (p_selfclear) else $error("shared reset did not self clear");
  property p_suppress;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && timer0_counter_write_i) |=> !compare_match_o;
  endproperty
  a_suppress: assert property (p_suppress) else $error("match after counter write");
  c_cmp_irq: cover property (@(posedge clk_i) disable iff (!reset_n_i) compare_irq_o);
  c_ext_tick: cover property (@(posedge clk_i) disable iff (!reset_n_i) timer0_clock_select_i == 3'h7 && timer0_tick_o);
  c_tsm: cover property (@(posedge clk_i) disable iff (!reset_n_i) sync_hold_mode_q && shared_prescaler_reset_q);

endmodule
`default_nettype wire

// File: testbench/ext_clock_source.sv
// Model of the external clock source that drives the timer count pins.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source #(
  parameter int HALF = 3
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Run control and the count pin.
  input wire logic run_i,
  output logic pin_o
);
  int cnt_q;
  // Toggles the pin every HALF cycles while running; the pin stays steady while stopped.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 0;
      pin_o <= 1'b0;
    end else if (run_i) begin
      if (cnt_q == HALF - 1) begin
        cnt_q <= 0;
        pin_o <= ~pin_o;
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end else begin
      cnt_q <= 0;
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_timer_prescaler_and_flags.sv
// Self-checking testbench for the timer prescaler and flag block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_timer_prescaler_and_flags;
  logic clk, rst_n, awv, wv, bry, arv, rry, cwr, ovf, btn, pcm, fcm, gie, cak, oak, run, pin_q;
  logic awr, wrd, bv, arr, rv, t0, t1, cm, ci, oi, ap, pin;
  logic [3:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [7:0] cnt;
  logic [2:0] s0, s1;
  logic [1:0] br, rr, rresp;
  int n_fail, compares, nt0, nt1, nm, nr, nf, k, a, b, c, e;
  int divs[5] = '{1, 8, 64, 256, 1024};
  logic [2:0] sels[5] = '{tmr_pkg::CS_DIRECT, tmr_pkg::CS_DIV8, tmr_pkg::CS_DIV64, tmr_pkg::CS_DIV256,
    tmr_pkg::CS_DIV1024};
  logic [3:0] offs[4] = '{tmr_pkg::OFF_COMPARE, tmr_pkg::OFF_MASK, tmr_pkg::OFF_FLAGS, tmr_pkg::OFF_GTC};
  timer_prescaler_and_flags #(.PRESC_WIDTH(10)) timer_prescaler_and_flags_i (
    .clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .timer0_counter_value_i(cnt), .timer0_counter_write_i(cwr), .timer0_overflow_i(ovf),
    .timer0_bottom_turn_i(btn), .phase_correct_mode_i(pcm), .force_compare_a_i(fcm),
    .timer0_clock_select_i(s0), .timer1_clock_select_i(s1),
    .ext_count_pin_zero_i(pin), .ext_count_pin_one_i(pin),
    .global_irq_enable_i(gie), .compare_ack_i(cak), .overflow_ack_i(oak),
    .timer0_tick_o(t0), .timer1_tick_o(t1), .compare_match_o(cm), .compare_irq_o(ci),
    .overflow_irq_o(oi), .async_prescaler_reset_o(ap));
  ext_clock_source #(.HALF(3)) ext_clock_source_i (.clk_i(clk), .reset_n_i(rst_n), .run_i(run), .pin_o(pin));
  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Counts ticks, matches and pin edges at the falling edge, where everything is settled.
  always @(negedge clk) begin
    if (t0 === 1'b1) nt0++;
    if (t1 === 1'b1) nt1++;
    if (cm === 1'b1) nm++;
    if (pin === 1'b1 && pin_q === 1'b0) nr++;
    if (pin === 1'b0 && pin_q === 1'b1) nf++;
    pin_q = pin;
  end
  // Register write; address and data are offered together and each is released when taken.
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    logic aok, wok;
    aok = 1'b0;
    wok = 1'b0;
    awa <= ad;
    wd <= {24'h000000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(aok && wok)) begin
      @(posedge clk);
      if (!aok && awr === 1'b1) begin
        awv <= 1'b0;
        aok = 1'b1;
      end
      if (!wok && wrd === 1'b1) begin
        wv <= 1'b0;
        wok = 1'b1;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    `CHK(br, tmr_pkg::RESP_OKAY)
  endtask
  // Register read; the answer is taken at the edge where rvalid is sampled high.
  task automatic rd(input logic [3:0] ad, output logic [31:0] v, output logic [1:0] rs);
    ara <= ad;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    v = rdat;
    rs = rresp;
  endtask
  // Waits for the next timer 0 tick.
  task automatic wait_t0();
    do @(posedge clk); while (t0 !== 1'b1);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    conclude();
  end
  // Test sequence.
  initial begin
    {rst_n, awv, wv, bry, arv, rry, cwr, ovf, btn, pcm, fcm, gie, cak, oak, run} = '0;
    {awa, ara, wd, cnt, s0, s1} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 4; k++) begin
      rd(offs[k], d, rr);
      `CHK(d, {24'h000000, tmr_pkg::RST_BYTE})
    end
    rd(4'h2, d, rr);
    `CHK(rr, tmr_pkg::RESP_SLVERR)
    `CHK(d, 32'h00000000)
    $display("test reset values done");
    wr(tmr_pkg::OFF_COMPARE, 8'hA5);
    rd(tmr_pkg::OFF_COMPARE, d, rr);
    `CHK(d, 32'h000000A5)
    wr(tmr_pkg::OFF_MASK, 8'h03);
    gie <= 1'b1;
    cnt <= 8'hA5;
    s0 <= tmr_pkg::CS_DIRECT;
    repeat (4) @(posedge clk);
    cnt <= 8'h10;
    repeat (3) @(posedge clk);
    `CHK(nm != 0, 1'b1)
    rd(tmr_pkg::OFF_FLAGS, d, rr);
    `CHK(d[1], 1'b1)
    `CHK(ci, 1'b1)
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(ci, 1'b0)
    gie <= 1'b1;
    wr(tmr_pkg::OFF_MASK, 8'h01);
    repeat (2) @(posedge clk);
    `CHK(ci, 1'b0)
    wr(tmr_pkg::OFF_FLAGS, 8'h02);
    rd(tmr_pkg::OFF_FLAGS, d, rr);
    `CHK(d[1], 1'b0)
    cnt <= 8'hA5;
    repeat (3) @(posedge clk);
    cnt <= 8'h10;
    repeat (2) @(posedge clk);
    cak <= 1'b1;
    @(posedge clk);
    cak <= 1'b0;
    fcm <= 1'b1;
    @(posedge clk);
    fcm <= 1'b0;
    rd(tmr_pkg::OFF_FLAGS, d, rr);
    `CHK(d[1], 1'b0)
    $display("test compare flag done");
    s0 <= tmr_pkg::CS_DIV8;
    wait_t0();
    cnt <= 8'hA5;
    cwr <= 1'b1;
    @(posedge clk);
    cwr <= 1'b0;
    a = nm;
    wait_t0();
    repeat (2) @(posedge clk);
    `CHK(nm - a, 0)
    wait_t0();
    repeat (2) @(posedge clk);
    `CHK(nm - a != 0, 1'b1)
    s0 <= tmr_pkg::CS_STOP;
    repeat (2) @(posedge clk);
    a = nt0;
    repeat (40) @(posedge clk);
    `CHK(nt0 - a, 0)
    cnt <= 8'h10;
    wr(tmr_pkg::OFF_FLAGS, 8'h02);
    $display("test counter write done");
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(oi, 1'b1)
    rd(tmr_pkg::OFF_FLAGS, d, rr);
    `CHK(d[0], 1'b1)
    oak <= 1'b1;
    @(posedge clk);
    oak <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(oi, 1'b0)
    pcm <= 1'b1;
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    rd(tmr_pkg::OFF_FLAGS, d, rr);
    `CHK(d[0], 1'b0)
    btn <= 1'b1;
    @(posedge clk);
    btn <= 1'b0;
    wr(tmr_pkg::OFF_MASK, 8'h00);
    rd(tmr_pkg::OFF_FLAGS, d, rr);
    `CHK(d[0], 1'b1)
    `CHK(oi, 1'b0)
    wr(tmr_pkg::OFF_FLAGS, 8'h01);
    rd(tmr_pkg::OFF_FLAGS, d, rr);
    `CHK(d[0], 1'b0)
    $display("test overflow flag done");
    for (k = 0; k < 5; k++) begin
      s0 <= sels[k];
      s1 <= sels[k];
      wait_t0();
      wait_t0();
      e = 0;
      do begin
        @(posedge clk);
        e++;
      end while (t0 !== 1'b1);
      `CHK(e, divs[k])
      `CHK(t1, 1'b1)
    end
    s0 <= tmr_pkg::CS_STOP;
    repeat (5) @(posedge clk);
    s0 <= tmr_pkg::CS_DIV64;
    e = 0;
    do begin
      @(posedge clk);
      e++;
    end while (t0 !== 1'b1);
    `CHK(e >= 1 && e <= 66, 1'b1)
    $display("test prescaler taps done");
    s0 <= tmr_pkg::CS_DIV8;
    s1 <= tmr_pkg::CS_DIV64;
    wr(tmr_pkg::OFF_GTC, 8'h83);
    rd(tmr_pkg::OFF_GTC, d, rr);
    `CHK(d, 32'h00000083)
    `CHK(ap, 1'b1)
    a = nt0;
    b = nt1;
    repeat (100) @(posedge clk);
    `CHK(nt0 - a + nt1 - b, 0)
    wr(tmr_pkg::OFF_GTC, 8'h00);
    a = -1;
    b = -1;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      if (t0 === 1'b1 && a < 0) a = k;
      if (t1 === 1'b1 && b < 0) b = k;
    end
    `CHK(b - a, 56)
    `CHK(ap, 1'b0)
    wr(tmr_pkg::OFF_GTC, 8'h01);
    rd(tmr_pkg::OFF_GTC, d, rr);
    `CHK(d, 32'h00000000)
    $display("test prescaler reset done");
    s0 <= tmr_pkg::CS_EXT_RISE;
    s1 <= tmr_pkg::CS_EXT_FALL;
    repeat (4) @(posedge clk);
    a = nt0;
    b = nt1;
    c = nr;
    e = nf;
    run <= 1'b1;
    repeat (60) @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(nr - c, 10)
    `CHK(nt0 - a, nr - c)
    `CHK(nt1 - b, nf - e)
    run <= 1'b1;
    do @(posedge clk); while (pin !== 1'b1);
    e = 0;
    do begin
      @(posedge clk);
      e++;
    end while (t0 !== 1'b1);
    `CHK(e >= 2 && e <= 4, 1'b1)
    run <= 1'b0;
    $display("test external clock done");
    conclude();
  end
endmodule
`default_nettype wire
